// *** rtl/ascd_pkg.sv ***
// Constants, field layouts and types of the serial command decoder.
// Assumes nothing beyond a SystemVerilog compiler.
package ascd_pkg;

  // Channel map
  localparam logic [3:0] TOP_CHAN = 4'hf;
  localparam logic [3:0] REFN_CHAN = 4'he;
  localparam logic [4:0] TOP_CHAN_W = 5'h0f;
  localparam logic [2:0] LAST_PAIR = 3'h7;

  // Byte layout
  localparam int BYTE_MSB = 7;
  localparam int RESET_FLAG_BIT = 3;
  localparam logic [2:0] BIT_CNT_LAST = 3'h7;

  // Clock modes
  localparam logic [1:0] CLK_PIN_INT = 2'h0;
  localparam logic [1:0] CLK_PIN_EXT = 2'h1;
  localparam logic [1:0] CLK_SERIAL_INT = 2'h2;
  localparam logic [1:0] CLK_SERIAL_EXT = 2'h3;

  // Reference modes
  localparam logic [1:0] REF_INT_ON = 2'h2;
  localparam logic [1:0] REF_EXT_DIFF = 2'h3;

  // Scan modes
  localparam logic [1:0] SCAN_LOW = 2'h0;
  localparam logic [1:0] SCAN_HIGH = 2'h1;
  localparam logic [1:0] SCAN_REPEAT = 2'h2;
  localparam logic [1:0] SCAN_SINGLE = 2'h3;

  // Kind of a received byte
  localparam logic [1:0] KIND_CMD = 2'h0;
  localparam logic [1:0] KIND_UNI = 2'h1;
  localparam logic [1:0] KIND_BI = 2'h2;

  // Decoded register target
  localparam logic [2:0] TGT_NONE = 3'h0;
  localparam logic [2:0] TGT_CONV = 3'h1;
  localparam logic [2:0] TGT_SETUP = 3'h2;
  localparam logic [2:0] TGT_AVG = 3'h3;
  localparam logic [2:0] TGT_RESET = 3'h4;

  // Counts
  localparam logic [4:0] REPEAT_UNIT = 5'h04;
  localparam logic [4:0] REPEAT_ONE = 5'h01;
  localparam logic [5:0] AVG_UNIT = 6'h04;
  localparam logic [5:0] AVG_ONE = 6'h01;

  typedef struct packed {
    logic [3:0] channel;
    logic [1:0] scan;
    logic temperature;
  } ascd_conv_t;

  typedef struct packed {
    logic [1:0] clock_mode;
    logic [1:0] ref_mode;
    logic [1:0] pair_sel;
  } ascd_setup_t;

  typedef struct packed {
    logic averaging_enable;
    logic [1:0] average_count;
    logic [1:0] repeat_count;
  } ascd_avg_t;

  typedef struct packed {
    logic [3:0] channel;
    logic differential;
    logic bipolar;
    logic twos_complement;
    logic temperature;
    logic [5:0] avg_count;
  } ascd_req_t;

  localparam ascd_conv_t CONV_RESET = '0;
  localparam ascd_avg_t AVG_RESET = '0;
  localparam ascd_setup_t SETUP_RESET = '{clock_mode: CLK_SERIAL_INT,
                                          ref_mode: 2'h0,
                                          pair_sel: 2'h0};
  localparam logic [7:0] PAIR_RESET = 8'h00;

  typedef enum logic [1:0] {SC_IDLE, SC_PICK, SC_WAIT} ascd_scan_state_t;

endpackage

// *** rtl/ascd_decoder.sv ***
// Serial command decoder: byte receiver on the link clock, register file
// and scan sequencer on sys_clk.
// Assumes a conversion core that takes one request at a time and answers
// each with a one-cycle conv_ack on sys_clk.
//
// Function
// - Byte leading bits pick conversion, setup, averaging or reset register.
// - Conversion bits 6:3 give channel 0-15; pairs named by lower channel.
// - Scan 00 converts channels 0 through N outside clock mode 11.
// - Scan 01 converts channels N through the highest channel outside clock mode 11.
// - Scan 10 converts N repeatedly outside clock mode 11; count from averaging repeat field.
// - Scan 11 converts channel N exactly once.
// - Modes 00/01 give one result per channel or pair, plus temperature.
// - Conversion bit 0 requests temperature as first result of the scan.
// - Channels serving as convert-start or reference are skipped.
// - Last pair ignored if either channel is convert-start or REF-.
// - Modes 10/11 start on conversion write; 00/01 on start-pin low pulse.
// - Setup bits 5:4 clock mode, 3:2 reference, 1:0 pair addressing.
// - Setup low bits 10/11 send next byte to unipolar/bipolar register.
// - Setup low bits 00/01 keep pair registers; next byte is a command.
// - Pair enabled in both registers is treated as unipolar.
// - Unipolar results straight binary, bipolar two's complement.
// - Averaging up to 32 samples per result; repeat count separate.
// - Averaging only while averaging enable bit 4 is set.
// - Clock mode 11 never averages.
// - Reset write: flag 1 clears the FIFO, flag 0 restores all defaults.
// - Power-up: blocks off, registers zero, setup clock mode 10.
// - Chip select falling starts a command; bytes taken only while low.
`timescale 1ns/1ps
module ascd_decoder (
  // System clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Serial link
  input wire logic link_sclk,
  input wire logic cs_b,
  input wire logic din,
  // Convert-start pin
  input wire logic convert_start_pin_b,
  // Conversion core
  output logic conv_req_valid,
  output ascd_pkg::ascd_req_t conv_req,
  input wire logic conv_ack,
  // Status and control
  output logic scan_busy,
  output logic fifo_clear,
  output logic ref_power_on,
  // Register contents
  output ascd_pkg::ascd_conv_t conversion_command,
  output ascd_pkg::ascd_setup_t setup_config,
  output ascd_pkg::ascd_avg_t averaging_config,
  output logic [7:0] unipolar_pair_select,
  output logic [7:0] bipolar_pair_select
);

  function automatic logic [2:0] byte_target(input logic [7:0] b);
    if (b[7]) return ascd_pkg::TGT_CONV;
    if (b[6]) return ascd_pkg::TGT_SETUP;
    if (b[5]) return ascd_pkg::TGT_AVG;
    if (b[4]) return ascd_pkg::TGT_RESET;
    return ascd_pkg::TGT_NONE;
  endfunction

  function automatic logic pair_bit(input logic [7:0] sel,
                                    input logic [3:0] ch);
    return sel[ascd_pkg::LAST_PAIR - ch[3:1]];
  endfunction

  function automatic logic chan_usable(input logic [3:0] ch,
                                       input logic [7:0] uni,
                                       input logic [7:0] bi,
                                       input ascd_pkg::ascd_setup_t su);
    logic res_top;
    logic res_ref;
    logic paired;
    res_top = !su.clock_mode[1];
    res_ref = su.ref_mode == ascd_pkg::REF_EXT_DIFF;
    paired = pair_bit(uni, ch) | pair_bit(bi, ch);
    if (res_top && ch == ascd_pkg::TOP_CHAN) return 1'b0;
    if (res_ref && ch == ascd_pkg::REFN_CHAN) return 1'b0;
    if (paired && ch[3:1] == ascd_pkg::LAST_PAIR && (res_top || res_ref))
      return 1'b0;
    if (paired && ch[0]) return 1'b0;
    return 1'b1;
  endfunction

  // ---------------- Link domain ----------------
  logic [2:0] lk_cnt_reg;
  logic [6:0] lk_shift_reg;
  logic [1:0] lk_expect_reg;
  logic [7:0] lk_byte_reg;
  logic [1:0] lk_kind_reg;
  logic lk_toggle_reg;
  logic [7:0] lk_byte_next;

  assign lk_byte_next = {lk_shift_reg, din};

  // Bit framing; CS high clears the frame
  always_ff @(posedge link_sclk or posedge cs_b) begin
    if (cs_b) begin
      lk_cnt_reg <= 3'h0;
      lk_shift_reg <= 7'h00;
      lk_expect_reg <= ascd_pkg::KIND_CMD;
    end else begin
      lk_cnt_reg <= lk_cnt_reg + 3'h1;
      lk_shift_reg <= lk_byte_next[6:0];
      if (lk_cnt_reg == ascd_pkg::BIT_CNT_LAST) begin
        if (lk_expect_reg == ascd_pkg::KIND_CMD &&
            byte_target(lk_byte_next) == ascd_pkg::TGT_SETUP &&
            lk_byte_next[1]) begin
          lk_expect_reg <= lk_byte_next[0] ? ascd_pkg::KIND_BI
                                           : ascd_pkg::KIND_UNI;
        end else begin
          lk_expect_reg <= ascd_pkg::KIND_CMD;
        end
      end
    end
  end

  // Completed byte held for the sys domain, flagged by a toggle
  always_ff @(posedge link_sclk or negedge rst_b) begin
    if (!rst_b) begin
      lk_byte_reg <= 8'h00;
      lk_kind_reg <= ascd_pkg::KIND_CMD;
      lk_toggle_reg <= 1'b0;
    end else if (!cs_b && lk_cnt_reg == ascd_pkg::BIT_CNT_LAST) begin
      lk_byte_reg <= lk_byte_next;
      lk_kind_reg <= lk_expect_reg;
      lk_toggle_reg <= !lk_toggle_reg;
    end
  end

  // ---------------- Crossings ----------------
  logic tg_meta_reg;
  logic tg_sync_reg;
  logic tg_last_reg;
  logic cs_pin_meta_reg;
  logic cs_pin_sync_reg;
  logic cs_pin_last_reg;
  logic byte_evt;
  logic start_pin_fall;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      tg_meta_reg <= 1'b0;
      tg_sync_reg <= 1'b0;
      tg_last_reg <= 1'b0;
    end else begin
      tg_meta_reg <= lk_toggle_reg;
      tg_sync_reg <= tg_meta_reg;
      tg_last_reg <= tg_sync_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cs_pin_meta_reg <= 1'b1;
      cs_pin_sync_reg <= 1'b1;
      cs_pin_last_reg <= 1'b1;
    end else begin
      cs_pin_meta_reg <= convert_start_pin_b;
      cs_pin_sync_reg <= cs_pin_meta_reg;
      cs_pin_last_reg <= cs_pin_sync_reg;
    end
  end

  assign byte_evt = tg_sync_reg ^ tg_last_reg;
  assign start_pin_fall = cs_pin_last_reg && !cs_pin_sync_reg;

  // Byte word is stable while the toggle crosses
  logic [7:0] rx_byte;
  logic [1:0] rx_kind;
  logic [2:0] rx_target;
  logic is_cmd;
  logic soft_reset;

  assign rx_byte = lk_byte_reg;
  assign rx_kind = lk_kind_reg;
  assign rx_target = byte_target(rx_byte);
  assign is_cmd = byte_evt && rx_kind == ascd_pkg::KIND_CMD;
  assign soft_reset = is_cmd && rx_target == ascd_pkg::TGT_RESET &&
                      !rx_byte[ascd_pkg::RESET_FLAG_BIT];

  // ---------------- Register file ----------------
  ascd_pkg::ascd_conv_t conv_reg;
  ascd_pkg::ascd_setup_t setup_reg;
  ascd_pkg::ascd_avg_t avg_reg;
  logic [7:0] uni_reg;
  logic [7:0] bi_reg;
  logic fifo_clear_reg;
  logic kick_reg;

  always_ff @(posedge sys_clk) begin
    if (!rst_b || soft_reset) begin
      conv_reg <= ascd_pkg::CONV_RESET;
      setup_reg <= ascd_pkg::SETUP_RESET;
      avg_reg <= ascd_pkg::AVG_RESET;
      uni_reg <= ascd_pkg::PAIR_RESET;
      bi_reg <= ascd_pkg::PAIR_RESET;
    end else if (byte_evt) begin
      if (rx_kind == ascd_pkg::KIND_UNI) begin
        uni_reg <= rx_byte;
      end else if (rx_kind == ascd_pkg::KIND_BI) begin
        bi_reg <= rx_byte;
      end else begin
        case (rx_target)
          ascd_pkg::TGT_CONV: conv_reg <= ascd_pkg::ascd_conv_t'(rx_byte[6:0]);
          ascd_pkg::TGT_SETUP: begin
            setup_reg <= ascd_pkg::ascd_setup_t'(rx_byte[5:0]);
          end
          ascd_pkg::TGT_AVG: avg_reg <= ascd_pkg::ascd_avg_t'(rx_byte[4:0]);
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      fifo_clear_reg <= 1'b0;
    end else begin
      fifo_clear_reg <= is_cmd && rx_target == ascd_pkg::TGT_RESET &&
                        rx_byte[ascd_pkg::RESET_FLAG_BIT];
    end
  end

  // Scan start request
  always_ff @(posedge sys_clk) begin
    if (!rst_b || soft_reset) begin
      kick_reg <= 1'b0;
    end else begin
      kick_reg <= (is_cmd && rx_target == ascd_pkg::TGT_CONV &&
                   setup_reg.clock_mode[1]) ||
                  (start_pin_fall && !setup_reg.clock_mode[1]);
    end
  end

  // ---------------- Scan sequencer ----------------
  ascd_pkg::ascd_scan_state_t state_reg;
  logic [4:0] cur_ch_reg;
  logic [4:0] end_ch_reg;
  logic [4:0] rep_left_reg;
  logic repeat_mode_reg;
  logic temp_pend_reg;
  logic [1:0] scan_mode_reg;
  logic [3:0] scan_sel_reg;
  ascd_pkg::ascd_req_t req_reg;
  logic [1:0] eff_scan;
  logic [5:0] avg_total;
  logic scan_done;
  logic cur_ok;
  logic cur_uni;
  logic cur_bi;

  assign eff_scan = (setup_reg.clock_mode == ascd_pkg::CLK_SERIAL_EXT) ?
                    ascd_pkg::SCAN_SINGLE : conv_reg.scan;
  assign avg_total = (avg_reg.averaging_enable &&
                      setup_reg.clock_mode != ascd_pkg::CLK_SERIAL_EXT) ?
                     6'(ascd_pkg::AVG_UNIT << avg_reg.average_count) :
                     ascd_pkg::AVG_ONE;
  assign scan_done = repeat_mode_reg ? (rep_left_reg == 5'h00)
                                     : (cur_ch_reg > end_ch_reg);
  assign cur_ok = chan_usable(cur_ch_reg[3:0], uni_reg, bi_reg,
                              setup_reg);
  assign cur_uni = pair_bit(uni_reg, cur_ch_reg[3:0]);
  assign cur_bi = pair_bit(bi_reg, cur_ch_reg[3:0]) && !cur_uni;

  always_ff @(posedge sys_clk) begin
    if (!rst_b || soft_reset) begin
      state_reg <= ascd_pkg::SC_IDLE;
      cur_ch_reg <= 5'h00;
      end_ch_reg <= 5'h00;
      rep_left_reg <= 5'h00;
      repeat_mode_reg <= 1'b0;
      temp_pend_reg <= 1'b0;
      scan_mode_reg <= ascd_pkg::SCAN_LOW;
      scan_sel_reg <= 4'h0;
      req_reg <= '0;
    end else begin
      case (state_reg)
        ascd_pkg::SC_IDLE: begin
          if (kick_reg) begin
            state_reg <= ascd_pkg::SC_PICK;
            scan_mode_reg <= eff_scan;
            scan_sel_reg <= conv_reg.channel;
            temp_pend_reg <= conv_reg.temperature;
            repeat_mode_reg <= eff_scan[1];
            cur_ch_reg <= (eff_scan == ascd_pkg::SCAN_LOW) ? 5'h00
                          : {1'b0, conv_reg.channel};
            end_ch_reg <= (eff_scan == ascd_pkg::SCAN_HIGH) ?
                          ascd_pkg::TOP_CHAN_W
                          : {1'b0, conv_reg.channel};
            if (eff_scan == ascd_pkg::SCAN_REPEAT) begin
              rep_left_reg <= 5'(({3'h0, avg_reg.repeat_count} +
                                  ascd_pkg::REPEAT_ONE) *
                                 ascd_pkg::REPEAT_UNIT);
            end else begin
              rep_left_reg <= ascd_pkg::REPEAT_ONE;
            end
          end
        end
        ascd_pkg::SC_PICK: begin
          if (temp_pend_reg) begin
            temp_pend_reg <= 1'b0;
            req_reg <= '{channel: 4'h0, differential: 1'b0, bipolar: 1'b0,
                         twos_complement: 1'b1, temperature: 1'b1,
                         avg_count: ascd_pkg::AVG_ONE};
            state_reg <= ascd_pkg::SC_WAIT;
          end else if (scan_done) begin
            state_reg <= ascd_pkg::SC_IDLE;
          end else if (cur_ok) begin
            req_reg <= '{channel: cur_ch_reg[3:0],
                         differential: cur_uni || cur_bi,
                         bipolar: cur_bi,
                         twos_complement: cur_bi,
                         temperature: 1'b0,
                         avg_count: avg_total};
            state_reg <= ascd_pkg::SC_WAIT;
          end else if (repeat_mode_reg) begin
            rep_left_reg <= rep_left_reg - 5'h01;
          end else begin
            cur_ch_reg <= cur_ch_reg + 5'h01;
          end
        end
        ascd_pkg::SC_WAIT: begin
          if (conv_ack) begin
            state_reg <= ascd_pkg::SC_PICK;
            if (req_reg.temperature) begin
              state_reg <= ascd_pkg::SC_PICK;
            end else if (repeat_mode_reg) begin
              rep_left_reg <= rep_left_reg - 5'h01;
            end else begin
              cur_ch_reg <= cur_ch_reg + 5'h01;
            end
          end
        end
        default: state_reg <= ascd_pkg::SC_IDLE;
      endcase
    end
  end

  // ---------------- Outputs ----------------
  assign conv_req_valid = state_reg == ascd_pkg::SC_WAIT;
  assign conv_req = req_reg;
  assign scan_busy = state_reg != ascd_pkg::SC_IDLE;
  assign fifo_clear = fifo_clear_reg;
  assign ref_power_on = setup_reg.ref_mode == ascd_pkg::REF_INT_ON ||
                        scan_busy;
  assign conversion_command = conv_reg;
  assign setup_config = setup_reg;
  assign averaging_config = avg_reg;
  assign unipolar_pair_select = uni_reg;
  assign bipolar_pair_select = bi_reg;

  // ---------------- Checks ----------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  a_decode_conv_write: assert property (
    is_cmd && rx_target == ascd_pkg::TGT_CONV && !soft_reset |=>
    conv_reg == $past(rx_byte[6:0]))
    else $error("conversion byte not stored");
  a_serial_start: assert property (
    is_cmd && rx_target == ascd_pkg::TGT_CONV && setup_reg.clock_mode[1] &&
    state_reg == ascd_pkg::SC_IDLE |-> ##2 state_reg == ascd_pkg::SC_PICK)
    else $error("serial write did not start scan");
  a_pin_start: assert property (
    start_pin_fall && !setup_reg.clock_mode[1] && !byte_evt &&
    state_reg == ascd_pkg::SC_IDLE |-> ##2 scan_busy)
    else $error("start pin pulse did not start scan");
  a_temp_first: assert property (
    state_reg == ascd_pkg::SC_PICK && temp_pend_reg |=>
    conv_req_valid && conv_req.temperature)
    else $error("temperature not first result");
  a_scan_low_range: assert property (
    conv_req_valid && !conv_req.temperature &&
    scan_mode_reg == ascd_pkg::SCAN_LOW |-> conv_req.channel <= scan_sel_reg)
    else $error("scan 00 went past N");
  a_scan_high_range: assert property (
    conv_req_valid && !conv_req.temperature &&
    scan_mode_reg == ascd_pkg::SCAN_HIGH |-> conv_req.channel >= scan_sel_reg)
    else $error("scan 01 went below N");
  a_single_chan: assert property (
    conv_req_valid && !conv_req.temperature && scan_mode_reg[1] |->
    conv_req.channel == scan_sel_reg)
    else $error("repeat or single scan left channel N");
  a_skip_reserved: assert property (
    conv_req_valid && !conv_req.temperature && !setup_reg.clock_mode[1] |->
    conv_req.channel != ascd_pkg::TOP_CHAN)
    else $error("start-pin channel converted");
  a_unipolar_wins: assert property (
    conv_req_valid && conv_req.bipolar |->
    !pair_bit(uni_reg, conv_req.channel) && conv_req.twos_complement)
    else $error("bipolar used over unipolar");
  a_no_avg_ext: assert property (
    conv_req_valid && setup_reg.clock_mode == ascd_pkg::CLK_SERIAL_EXT |->
    conv_req.avg_count == ascd_pkg::AVG_ONE)
    else $error("averaging in clock mode 11");
  a_fifo_clear_pulse: assert property (
    is_cmd && rx_target == ascd_pkg::TGT_RESET &&
    rx_byte[ascd_pkg::RESET_FLAG_BIT] |=> fifo_clear ##1 !fifo_clear)
    else $error("FIFO clear not a single pulse");
  a_soft_defaults: assert property (
    soft_reset |=> setup_reg == ascd_pkg::SETUP_RESET && uni_reg == 8'h00 &&
    !scan_busy)
    else $error("soft reset left state");
  a_pair_keep: assert property (
    byte_evt && rx_kind != ascd_pkg::KIND_CMD |->
    setup_reg.pair_sel == (rx_kind == ascd_pkg::KIND_BI ? 2'h3 : 2'h2))
    else $error("pair data without pair address");

  c_scan_temp: cover property (state_reg == ascd_pkg::SC_PICK &&
                               temp_pend_reg);
  c_repeat_scan: cover property (conv_req_valid &&
                                 scan_mode_reg == ascd_pkg::SCAN_REPEAT);
  c_bipolar_req: cover property (conv_req_valid && conv_req.bipolar);
  c_pair_write: cover property (byte_evt && rx_kind == ascd_pkg::KIND_UNI);

endmodule // ascd_decoder

// *** dv/ascd_host_model.sv ***
// Serial host model: chip select, link clock and data.
// Assumes the decoder samples data on rising link clock edges.
`timescale 1ns/1ps
module ascd_host_model (
  // Serial link
  output logic link_sclk,
  output logic cs_b,
  output logic din
);
  initial begin
    link_sclk = 1'b0;
    // Raised after time zero so the framing clear sees an edge
    cs_b <= 1'b1;
    din = 1'b1;
  end

  // One or two bytes; link clock still outside the frame
  task automatic send(input logic [7:0] b0, input logic [7:0] b1,
                      input bit two);
    logic [15:0] data;
    data = {b0, b1};
    #3 cs_b = 1'b0;
    for (int i = 15; i >= (two ? 0 : 8); i--) begin
      din = data[i];
      #6 link_sclk = 1'b1;
      #6 link_sclk = 1'b0;
      // Byte spacing kept above the capture time
      if (i == 8) #60;
    end
    #6 cs_b = 1'b1;
    din = ~din;
  endtask
endmodule // ascd_host_model

// *** dv/tb.sv ***
// Testbench of the serial command decoder with a conversion core model.
// Assumes package, decoder and host model are compiled first.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin \
  n_errors++; $display("mismatch %s exp %h got %h", nm, ex, gt); end end
module tb;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b1;
  logic convert_start_pin_b = 1'b1;
  logic conv_ack = 1'b0;
  int n_clear = 0;
  int n_clear_base = 0;
  int seen_base = 0;
  logic link_sclk, cs_b, din;
  logic conv_req_valid, scan_busy, fifo_clear, ref_power_on;
  logic [7:0] unipolar_pair_select, bipolar_pair_select;
  logic [15:0] pairs;
  ascd_pkg::ascd_req_t conv_req;
  ascd_pkg::ascd_conv_t conversion_command;
  ascd_pkg::ascd_setup_t setup_config;
  ascd_pkg::ascd_avg_t averaging_config;
  ascd_pkg::ascd_req_t seen_q[$];
  ascd_pkg::ascd_req_t exp_q[$];
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  int ack_wait = 0;
  logic [31:0] rng = 32'hf7c0b466;
  logic [31:0] r;
  logic [7:0] uni, bi, cv, av, su;

  always #12.5 sys_clk = ~sys_clk;
  assign pairs = {unipolar_pair_select, bipolar_pair_select};

  ascd_host_model i_ascd_host_model (.link_sclk(link_sclk), .cs_b(cs_b),
    .din(din));
  ascd_decoder i_ascd_decoder (.sys_clk(sys_clk), .rst_b(rst_b),
    .link_sclk(link_sclk), .cs_b(cs_b), .din(din),
    .convert_start_pin_b(convert_start_pin_b),
    .conv_req_valid(conv_req_valid), .conv_req(conv_req),
    .conv_ack(conv_ack), .scan_busy(scan_busy), .fifo_clear(fifo_clear),
    .ref_power_on(ref_power_on), .conversion_command(conversion_command),
    .setup_config(setup_config), .averaging_config(averaging_config),
    .unipolar_pair_select(unipolar_pair_select),
    .bipolar_pair_select(bipolar_pair_select));

  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  function automatic ascd_pkg::ascd_req_t mk(logic [3:0] ch, logic d,
                                             logic b, logic t, logic [5:0] n);
    return '{channel: ch, differential: d, bipolar: b,
             twos_complement: b | t, temperature: t, avg_count: n};
  endfunction

  function automatic logic rsv(logic [3:0] ch);
    return (ch == 4'hf && !su[5]) || (ch == 4'he && su[3:2] == 2'h3);
  endfunction

  // Expected request list from the register bytes last written
  function automatic void build_exp();
    logic [5:0] n;
    logic [3:0] lo, hi;
    logic [2:0] p;
    logic en, bp, one;
    int reps;
    one = su[5:4] == 2'h3;
    n = (av[4] && !one) ? 6'h04 << av[3:2] : 6'h01;
    exp_q = {};
    if (cv[0]) exp_q.push_back(mk(4'h0, 1'b0, 1'b0, 1'b1, 6'h01));
    lo = cv[6:3];
    hi = cv[6:3];
    reps = 1;
    if (!one && cv[2:1] == 2'h0) lo = 4'h0;
    if (!one && cv[2:1] == 2'h1) hi = 4'hf;
    if (!one && cv[2:1] == 2'h2) reps = 4 * (av[1:0] + 1);
    for (int c = lo; c <= hi; c++) begin
      p = c[3:1];
      en = uni[7 - p] | bi[7 - p];
      bp = !uni[7 - p] & bi[7 - p];
      if (rsv(c[3:0]) || (en && c[0])) continue;
      if (en && p == 3'h7 && (rsv(4'he) || rsv(4'hf))) continue;
      repeat (reps) exp_q.push_back(mk(c[3:0], en, bp, 1'b0, n));
    end
  endfunction

  // Conversion core: acknowledges after a varying delay
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      conv_ack <= 1'b0;
    end else if (conv_req_valid === 1'b1 && !conv_ack) begin
      if (ack_wait == 0) begin
        conv_ack <= 1'b1;
        seen_q.push_back(conv_req);
        ack_wait <= seen_q.size() % 3;
      end else begin
        ack_wait <= ack_wait - 1;
      end
    end else begin
      conv_ack <= 1'b0;
    end
  end

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (fifo_clear === 1'b1) n_clear <= n_clear + 1;
    if (cycles == 20000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wr(logic [7:0] b0, logic [7:0] b1, bit two);
    @(posedge sys_clk);
    i_ascd_host_model.send(b0, b1, two);
    tick(8);
  endtask

  task automatic run_scan(string nm);
    int k;
    k = 0;
    while (scan_busy !== 1'b1 && k < 40) begin
      tick(1);
      k++;
    end
    while (scan_busy === 1'b1 && k < 4000) begin
      tick(1);
      k++;
    end
    `CHK(nm, exp_q.size(), seen_q.size() - seen_base)
    foreach (exp_q[i])
      if (seen_base + i < seen_q.size())
        `CHK(nm, exp_q[i], seen_q[seen_base + i])
    $display("test %s done", nm);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    // Falling edge after time zero so the link byte hold resets
    rst_b <= 1'b0;
    tick(8);
    rst_b <= 1'b1;
    tick(2);
    `CHK("setup", 6'h20, setup_config)
    `CHK("conversion", 7'h00, conversion_command)
    `CHK("averaging", 5'h00, averaging_config)
    `CHK("pairs", 16'h0, pairs)
    `CHK("ref power", 1'b0, ref_power_on)
    r = rnd();
    uni = r[7:0];
    bi = r[15:8];
    wr(8'h62, uni, 1);
    `CHK("unipolar", uni, unipolar_pair_select)
    wr(8'h63, bi, 1);
    `CHK("bipolar", bi, bipolar_pair_select)
    wr(8'h6d, 8'h3b, 1);
    `CHK("kept", {uni, bi}, pairs)
    `CHK("setup", 6'h2d, setup_config)
    `CHK("averaging", 5'h1b, averaging_config)
    // Pair address cut by frame end: next frame opens with a command
    wr(8'h62, 8'h00, 0);
    wr(8'h2c, 8'h00, 0);
    `CHK("cut pair", uni, unipolar_pair_select)
    `CHK("cut avg", 5'h0c, averaging_config)
    $display("test registers done");
    for (int t = 0; t < 12; t++) begin
      r = rnd();
      su = {3'h3, r[0], r[2:1], 2'h0};
      uni = r[15:8];
      bi = r[23:16];
      av = {3'h1, r[28:24]};
      r = rnd();
      cv = {1'b1, r[6:0]};
      if (cv[2]) cv[3] = 1'b0;
      wr({su[7:2], 2'h3}, bi, 1);
      wr({su[7:2], 2'h2}, uni, 1);
      wr(av, 8'h00, 0);
      `CHK("ref power", su[3:2] == 2'h2, ref_power_on)
      build_exp();
      seen_base = seen_q.size();
      wr(cv, 8'h00, 0);
      `CHK("conversion", cv[6:0], conversion_command)
      run_scan("random scan");
    end
    su = 8'h4e;
    uni = 8'h01;
    bi = 8'h00;
    av = 8'h30;
    cv = 8'hf9;
    wr(8'h4f, bi, 1);
    wr(su, uni, 1);
    wr(av, 8'h00, 0);
    build_exp();
    seen_base = seen_q.size();
    wr(cv, 8'h00, 0);
    tick(20);
    `CHK("serial start", 1'b0, scan_busy)
    convert_start_pin_b <= 1'b0;
    tick(4);
    convert_start_pin_b <= 1'b1;
    run_scan("pin scan");
    n_clear_base = n_clear;
    wr(8'h18, 8'h00, 0);
    `CHK("fifo clear", n_clear_base + 1, n_clear)
    `CHK("setup kept", 6'h0e, setup_config)
    wr(8'h10, 8'h00, 0);
    `CHK("defaults", 6'h20, setup_config)
    `CHK("pairs", 16'h0, pairs)
    `CHK("averaging", 5'h00, averaging_config)
    `CHK("conversion", 7'h00, conversion_command)
    $display("test reset byte done");
    stop_test();
  end
endmodule // tb
